// ==== design/iwd_watchdog.sv ====
`timescale 1ns/10ps
`include "iwd_defines.svh"
module iwd_watchdog #(
	parameter int unsigned TICK_CYCLES = `IWD_TICK_CYCLES
) (
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            arst_n,
	// boot default, sampled after reset release
	input  wire logic            boot_en,
	input  wire iwd_pkg::iwd_byte_t boot_timeout,
	input  wire logic            boot_seconds,
	// i/o port access, synchronous strobes
	input  wire iwd_pkg::iwd_addr_t io_addr,
	input  wire logic            io_wr,
	input  wire logic            io_rd,
	input  wire iwd_pkg::iwd_byte_t io_wdata,
	output iwd_pkg::iwd_byte_t   io_rdata,
	output logic                 io_rvalid,
	// status and reset out
	output logic                 wdt_active,
	output logic                 cpu_rst
);
	import iwd_pkg::*;

	iwd_state_t state_ff, nxt_state;
	iwd_byte_t  timeout_ff, nxt_timeout;
	iwd_byte_t  remain_ff, nxt_remain;
	iwd_byte_t  rdata_ff, nxt_rdata;
	logic       unit_sec_ff, nxt_unit_sec;
	logic       boot_done_ff;
	logic [5:0] min_ff, nxt_min;
	logic [4:0] rst_ff, nxt_rst;
	logic       rvalid_ff, active_ff, cpu_rst_ff;

	// registers decoded straight from the port address
	wire sel_ctrl  = (io_addr == `IWD_ADDR_UNIT_CTRL);
	wire sel_tmo   = (io_addr == `IWD_ADDR_TIMEOUT);
	wire wr_ctrl   = io_wr && sel_ctrl;
	wire wr_tmo    = io_wr && sel_tmo;
	wire boot_load = !boot_done_ff && boot_en;
	wire restart   = wr_tmo || boot_load;
	wire sec_tick;

	// seconds time base; restarted by service so a unit is whole
	iwd_divider #(
		.LIMIT   (TICK_CYCLES)
	) u_div (
		.core_clk(core_clk),
		.arst_n  (arst_n),
		.restart (restart),
		.tick    (sec_tick)
	);

	wire min_end  = (min_ff == 6'(`IWD_SECS_PER_MIN - 1));
	wire unit_end = sec_tick && (unit_sec_ff || min_end);
	wire expire   = (state_ff == IWD_COUNT) && unit_end &&
		(remain_ff == 8'h01);

	assign nxt_unit_sec = wr_ctrl ? io_wdata[`IWD_UNIT_SECONDS_BIT] :
		(boot_load ? boot_seconds : unit_sec_ff);
	assign nxt_timeout  = wr_tmo ? io_wdata :
		(boot_load ? boot_timeout : timeout_ff);
	assign nxt_min = (restart || unit_sec_ff) ? 6'h00 :
		(sec_tick ? (min_end ? 6'h00 : min_ff + 6'h01) : min_ff);
	assign nxt_rst = (state_ff == IWD_RESET) ? rst_ff - 5'h01 :
		5'(`IWD_CPU_RST_CYCLES);
	// reads: bit 7 of control, other bits zero
	assign nxt_rdata = sel_ctrl ?
		{unit_sec_ff, 7'h00} : (sel_tmo ? timeout_ff : 8'h00);

	always_comb begin
		nxt_state  = state_ff;
		nxt_remain = remain_ff;
		case (state_ff)
			IWD_IDLE: begin
				if (restart && nxt_timeout != 8'h00) begin
					nxt_state  = IWD_COUNT;
					nxt_remain = nxt_timeout;
				end
			end
			IWD_COUNT: begin
				if (restart) begin
					nxt_remain = nxt_timeout;
					if (nxt_timeout == 8'h00)
						nxt_state = IWD_IDLE;
				end else if (expire) begin
					nxt_state = IWD_RESET;
				end else if (unit_end) begin
					nxt_remain = remain_ff - 8'h01;
				end
			end
			IWD_RESET: begin
				// pulse stretched, then dormant until rewritten
				if (rst_ff == 5'h01) begin
					nxt_state = IWD_IDLE;
				end
			end
			default: begin
				nxt_state = IWD_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff     <= IWD_IDLE;
			timeout_ff   <= `IWD_TIMEOUT_RST;
			remain_ff    <= 8'h00;
			unit_sec_ff  <= 1'b0;
			boot_done_ff <= 1'b0;
			min_ff       <= 6'h00;
			rst_ff       <= 5'h00;
			rdata_ff     <= 8'h00;
			rvalid_ff    <= 1'b0;
			active_ff    <= 1'b0;
			cpu_rst_ff   <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			timeout_ff   <= nxt_timeout;
			remain_ff    <= nxt_remain;
			unit_sec_ff  <= nxt_unit_sec;
			boot_done_ff <= 1'b1;
			min_ff       <= nxt_min;
			rst_ff       <= nxt_rst;
			rdata_ff     <= io_rd ? nxt_rdata : 8'h00;
			rvalid_ff    <= io_rd;
			active_ff    <= (nxt_state == IWD_COUNT);
			cpu_rst_ff   <= (nxt_state == IWD_RESET);
		end
	end

	assign io_rdata   = rdata_ff;
	assign io_rvalid  = rvalid_ff;
	assign wdt_active = active_ff;
	assign cpu_rst    = cpu_rst_ff;
endmodule : iwd_watchdog

// ==== inc/iwd_defines.svh ====
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH

// register offsets
`define IWD_ADDR_UNIT_CTRL    16'h0565
`define IWD_ADDR_TIMEOUT      16'h0566
// field positions
`define IWD_UNIT_SECONDS_BIT  7
// reset values
`define IWD_TIMEOUT_RST       8'h00
`define IWD_UNIT_CTRL_RST     8'h00
// timing
`define IWD_CLK_HZ            100000000
`define IWD_TICK_S            1
`define IWD_TICK_CYCLES       (`IWD_CLK_HZ * `IWD_TICK_S)
`define IWD_SECS_PER_MIN      60
`define IWD_CPU_RST_CYCLES    16

`endif

// ==== inc/iwd_pkg.sv ====
package iwd_pkg;
	typedef logic [15:0] iwd_addr_t;
	typedef logic [7:0]  iwd_byte_t;
	typedef enum logic [1:0] {
		IWD_IDLE  = 2'b00,
		IWD_COUNT = 2'b01,
		IWD_RESET = 2'b11
	} iwd_state_t;
endpackage : iwd_pkg

// ==== design/iwd_divider.sv ====
`timescale 1ns/10ps
// free counter giving a one-cycle enable every LIMIT cycles
module iwd_divider #(
	parameter int unsigned LIMIT = 100
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// control
	input  wire logic restart,
	// enable out
	output logic      tick
);
	localparam int unsigned W = (LIMIT > 1) ? $clog2(LIMIT) : 1;
	localparam logic [W-1:0] LAST = W'(LIMIT - 1);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic         tick_ff;
	wire          at_last = (cnt_ff == LAST);

	assign nxt_cnt = (restart || at_last) ? '0 : cnt_ff + W'(1);
	assign tick    = tick_ff;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= at_last && !restart;
		end
	end
endmodule : iwd_divider

// ==== sim/iwd_host.sv ====
`timescale 1ns/10ps
module iwd_host (
	// clock and answer
	input wire logic core_clk,
	input wire logic io_rvalid,
	input wire iwd_pkg::iwd_byte_t io_rdata,
	// port access
	output iwd_pkg::iwd_addr_t io_addr,
	output logic io_wr,
	output logic io_rd,
	output iwd_pkg::iwd_byte_t io_wdata
);
	import iwd_pkg::*;
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// service is a rewrite of the count
	task automatic wr(input iwd_addr_t a, input iwd_byte_t d);
		@(negedge core_clk);
		{io_addr, io_wdata, io_wr} = {a, d, 1'b1};
		@(negedge core_clk);
		// idle bus shows no stale value
		{io_addr, io_wdata, io_wr} = {~a, ~d, 1'b0};
	endtask : wr
	task automatic rd(input iwd_addr_t a, output iwd_byte_t d);
		@(negedge core_clk);
		{io_addr, io_rd} = {a, 1'b1};
		@(negedge core_clk);
		{io_addr, io_rd} = {~a, 1'b0};
		d = io_rvalid ? io_rdata : 8'hEE;
	endtask : rd
endmodule : iwd_host

// ==== sim/iwd_watchdog_chk.sv ====
`timescale 1ns/10ps
module iwd_watchdog_chk #(parameter int TICK_CYCLES = 10) (
	input wire logic core_clk, arst_n, io_wr, wdt_active, cpu_rst,
	input wire iwd_pkg::iwd_addr_t io_addr,
	input wire iwd_pkg::iwd_byte_t io_wdata
);
	import iwd_pkg::*;
	localparam int SLO = TICK_CYCLES - 1;
	localparam int SHI = TICK_CYCLES + 4;
	localparam int MLO = 60 * TICK_CYCLES - 1;
	localparam int MHI = 60 * TICK_CYCLES + 4;
	logic sec_ff;
	wire wt = io_wr && io_addr == 16'h0566;
	wire nz = wt && io_wdata != 8'h00;
	wire one = wt && io_wdata == 8'h01;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n) sec_ff <= 1'b0;
		else if (io_wr && io_addr == 16'h0565) sec_ff <= io_wdata[7];
	sequence hi8; cpu_rst [*8]; endsequence
	init_idle_a: assert property (!$past(arst_n) |-> !wdt_active)
		else $error("active at reset");
	load_on_a: assert property (nz |=> wdt_active)
		else $error("not enabled");
	zero_off_a: assert property (wt && !nz |=> !wdt_active)
		else $error("not disabled");
	svc_hold_a: assert property (nz |=> (!$rose(cpu_rst)) [*8])
		else $error("early reset");
	rst_cause_a: assert property ($rose(cpu_rst) |-> $past(wdt_active))
		else $error("reset while idle");
	rst_len_a: assert property ($rose(cpu_rst) |-> hi8 ##1 hi8 ##1 !cpu_rst)
		else $error("reset width");
	sec_time_a: assert property (one && sec_ff |-> ##[SLO:SHI] $rose(cpu_rst))
		else $error("second timing");
	min_time_a: assert property (one && !sec_ff |-> ##[MLO:MHI] $rose(cpu_rst))
		else $error("minute timing");
endmodule : iwd_watchdog_chk
bind iwd_watchdog iwd_watchdog_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ==== sim/iwd_watchdog_tb.sv ====
`timescale 1ns/10ps
`define CK(a, b) n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD %0t %h %h", $time, (a), (b)); end
module iwd_watchdog_tb;
	import iwd_pkg::*;
	localparam int T = 10;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic io_wr, io_rd, io_rvalid, wdt_active, cpu_rst;
	iwd_addr_t io_addr;
	iwd_byte_t io_wdata, io_rdata, d;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	logic boot_en = 1'b0;
	logic boot_seconds = 1'b0;
	iwd_byte_t boot_timeout = 8'h00;
	iwd_watchdog #(.TICK_CYCLES(T)) DUT (.boot_en(boot_en),
		.boot_timeout(boot_timeout), .boot_seconds(boot_seconds), .*);
	iwd_host host (.*);
	task automatic results;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	// bounded wait so a dead timer cannot hang the run
	task automatic expiry(input int lo, input int hi);
		for (n = 0; n < hi && cpu_rst !== 1'b1; n++) @(negedge core_clk);
		`CK(n >= lo && cpu_rst === 1'b1, 1'b1)
		repeat (20) @(negedge core_clk);
	endtask : expiry
	task automatic t_sec;
		`CK({wdt_active, cpu_rst}, 2'b00)
		host.rd(16'h0567, d);
		`CK(d, 8'h00)
		host.wr(16'h0565, 8'h80);
		host.rd(16'h0565, d);
		`CK(d, 8'h80)
		host.wr(16'h0566, 8'h01);
		`CK(wdt_active, 1'b1)
		expiry(T - 2, T + 6);
		$display("seconds done");
	endtask : t_sec
	task automatic t_svc;
		repeat (4) begin
			host.wr(16'h0566, 8'h02);
			repeat (15) @(negedge core_clk);
		end
		expiry(T - 7, T + 2);
		host.wr(16'h0566, 8'h02);
		host.wr(16'h0566, 8'h00);
		for (int i = 0; i < 40; i++) begin
			@(negedge core_clk);
			`CK({wdt_active, cpu_rst}, 2'b00)
		end
		$display("service done");
	endtask : t_svc
	task automatic t_min;
		host.wr(16'h0565, 8'h00);
		// long boot-style timeout, then a shorter rewrite restarts it
		host.wr(16'h0566, 8'h05);
		host.rd(16'h0566, d);
		`CK(d, 8'h05)
		host.wr(16'h0566, 8'h01);
		`CK(wdt_active, 1'b1)
		expiry(60 * T - 3, 60 * T + 6);
		$display("minutes done");
	endtask : t_min
	// mid-run reset with the stored boot setting enabled
	task automatic t_boot;
		@(negedge core_clk);
		arst_n = 1'b0;
		{boot_en, boot_timeout, boot_seconds} = {1'b1, 8'h02, 1'b1};
		repeat (16) @(negedge core_clk);
		`CK({wdt_active, cpu_rst}, 2'b00)
		arst_n = 1'b1;
		@(negedge core_clk);
		`CK(wdt_active, 1'b1)
		expiry(2 * T - 4, 2 * T + 6);
		boot_en = 1'b0;
		host.rd(16'h0566, d);
		`CK(d, 8'h02)
		$display("boot done");
	endtask : t_boot
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		repeat (16) @(negedge core_clk);
		arst_n = 1'b1;
		t_sec();
		t_svc();
		t_min();
		t_boot();
		results();
	end
endmodule : iwd_watchdog_tb
